// file: core/acr_pkg.sv
package acr_pkg;
  localparam int unsigned ADDR_W = 7;

  localparam logic [6:0] OFS_MIS    = 7'h00;
  localparam logic [6:0] OFS_RIS    = 7'h04;
  localparam logic [6:0] OFS_INTEN  = 7'h08;
  localparam logic [6:0] OFS_REFCTL = 7'h10;
  localparam logic [6:0] OFS_STAT0  = 7'h20;
  localparam logic [6:0] OFS_CTL0   = 7'h24;
  localparam logic [6:0] OFS_STAT1  = 7'h40;
  localparam logic [6:0] OFS_CTL1   = 7'h44;

  localparam int unsigned REF_POWER_BIT = 9;
  localparam int unsigned REF_RANGE_BIT = 8;
  localparam int unsigned REF_TAP_LSB   = 0;
  localparam int unsigned STAT_OUT_BIT  = 1;
  localparam int unsigned CTL_INV_BIT   = 1;
  localparam int unsigned CTL_SENSE_LSB = 2;
  localparam int unsigned CTL_POL_BIT   = 4;
  localparam int unsigned CTL_SRC_LSB   = 9;

  localparam logic [31:0] REG_RST     = 32'h0000_0000;
  localparam logic [31:0] REF_HI_MASK = 32'h0000_0300;
  localparam logic [31:0] REF_LO_MASK = 32'h0000_000f;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SENSE_LEVEL = 2'b00,
    SENSE_FALL  = 2'b01,
    SENSE_RISE  = 2'b10,
    SENSE_BOTH  = 2'b11
  } acr_sense_t;

  typedef struct packed {
    logic [1:0] src_sel;
    logic       level_sense_polarity;
    acr_sense_t interrupt_sense_select;
    logic       output_invert;
  } acr_cmp_ctrl_t;

  typedef struct packed {
    logic       power;
    logic       ladder_range_select;
    logic [3:0] tap;
  } acr_ladder_t;
endpackage

// file: core/acr_sense.sv
module acr_sense (
  input  wire logic                   aclk,      // System clock
  input  wire logic                   aresetn,   // Sync reset, low
  input  wire logic                   cmp_in,    // Comparator output
  input  wire acr_pkg::acr_cmp_ctrl_t ctrl,      // Per-comparator control
  output logic                        cond_out,  // Conditioned output
  output logic                        event_out  // Interrupt event
);
  logic cond_reg, cond_next;
  logic primed_reg, primed_next;
  logic cond_now;
  logic rise, fall;

  always_comb begin
    cond_now    = cmp_in ^ ctrl.output_invert; // [RL14]
    rise        = primed_reg && cond_now && !cond_reg;
    fall        = primed_reg && !cond_now && cond_reg;
    cond_next   = cond_now;
    primed_next = 1'b1;
    case (ctrl.interrupt_sense_select) // [RL12]
      acr_pkg::SENSE_LEVEL: event_out = (cond_now == ctrl.level_sense_polarity); // [RL13]
      acr_pkg::SENSE_FALL:  event_out = fall;
      acr_pkg::SENSE_RISE:  event_out = rise;
      acr_pkg::SENSE_BOTH:  event_out = rise || fall;
      default:              event_out = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      cond_reg   <= cond_next;
      primed_reg <= primed_next;
    end
  end

  assign cond_out = cond_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rise_event: assert property ( // [RL12]
    (primed_reg && ctrl.interrupt_sense_select == acr_pkg::SENSE_RISE
     && !cond_reg && cond_now) |-> event_out)
    else $error("rising edge gave no event");

  a_fall_only: assert property ( // [RL12]
    (ctrl.interrupt_sense_select == acr_pkg::SENSE_FALL && cond_now) |-> !event_out)
    else $error("falling sense fired on high output");

  a_invert_level: assert property ( // [RL14]
    (ctrl.output_invert && ctrl.interrupt_sense_select == acr_pkg::SENSE_LEVEL
     && ctrl.level_sense_polarity && !cmp_in) |-> event_out ##1 cond_out)
    else $error("inverted low output not seen as high");
endmodule

// file: core/acr_regs.sv
// Notes on behaviour
// RL1: Masked status: bit per comparator after enable.
// RL2: Raw status bit set by comparator event.
// RL3: Enable bit lets comparator drive interrupt.
// RL4: Masked equals raw AND enable; irq ORs.
// RL5: Ladder power bit 9, resets to zero.
// RL6: Power bit one connects ladder to supply.
// RL7: Range bit 8: 32 R or 24 R.
// RL8: Tap field bits 3:0 steer reference mux.
// RL9: Status bit 1 shows comparator output value.
// RL10: Status registers at 0x20 and 0x40.
// RL11: Reserved bits read-only; software preserves them.
// RL12: Sense field: level, fall, rise, either edge.
// RL13: Level mode polarity picks low or high.
// RL14: Invert bit flips output before all use.
//
// Local design decision: the AXI4-Lite register port.
module acr_regs (
  input  wire logic                   aclk,          // System clock
  input  wire logic                   aresetn,       // Sync reset, low
  input  wire logic [6:0]             awaddr,        // Write address
  input  wire logic [2:0]             awprot,        // Unused protection
  input  wire logic                   awvalid,       // Write address valid
  output logic                        awready,       // Write address ready
  input  wire logic [31:0]            wdata,         // Write data
  input  wire logic [3:0]             wstrb,         // Byte strobes
  input  wire logic                   wvalid,        // Write data valid
  output logic                        wready,        // Write data ready
  output logic [1:0]                  bresp,         // Write response
  output logic                        bvalid,        // Write response valid
  input  wire logic                   bready,        // Write response ready
  input  wire logic [6:0]             araddr,        // Read address
  input  wire logic [2:0]             arprot,        // Unused protection
  input  wire logic                   arvalid,       // Read address valid
  output logic                        arready,       // Read address ready
  output logic [31:0]                 rdata,         // Read data
  output logic [1:0]                  rresp,         // Read response
  output logic                        rvalid,        // Read data valid
  input  wire logic                   rready,        // Read data ready
  input  wire logic                   cmp0_in,       // Comparator 0 output
  input  wire logic                   cmp1_in,       // Comparator 1 output
  output acr_pkg::acr_ladder_t        ladder,        // Ladder power, range, tap
  output logic [1:0]                  cmp0_src_sel,  // Comparator 0 input source
  output logic [1:0]                  cmp1_src_sel,  // Comparator 1 input source
  output logic                        irq            // Interrupt request
);
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic acr_pkg::acr_ladder_t to_ladder(input logic [31:0] w);
    acr_pkg::acr_ladder_t l;
    l.power               = w[acr_pkg::REF_POWER_BIT];
    l.ladder_range_select = w[acr_pkg::REF_RANGE_BIT];
    l.tap                 = w[acr_pkg::REF_TAP_LSB +: 4];
    return l;
  endfunction

  function automatic logic [31:0] ladder_word(input acr_pkg::acr_ladder_t l);
    logic [31:0] w;
    w                              = '0;
    w[acr_pkg::REF_POWER_BIT]      = l.power;
    w[acr_pkg::REF_RANGE_BIT]      = l.ladder_range_select;
    w[acr_pkg::REF_TAP_LSB +: 4]   = l.tap;
    return w;
  endfunction

  function automatic acr_pkg::acr_cmp_ctrl_t to_ctrl(input logic [31:0] w);
    acr_pkg::acr_cmp_ctrl_t c;
    c.src_sel                = w[acr_pkg::CTL_SRC_LSB +: 2];
    c.level_sense_polarity   = w[acr_pkg::CTL_POL_BIT];
    c.interrupt_sense_select = acr_pkg::acr_sense_t'(w[acr_pkg::CTL_SENSE_LSB +: 2]);
    c.output_invert          = w[acr_pkg::CTL_INV_BIT];
    return c;
  endfunction

  function automatic logic [31:0] ctrl_word(input acr_pkg::acr_cmp_ctrl_t c);
    logic [31:0] w;
    w                              = '0;
    w[acr_pkg::CTL_SRC_LSB +: 2]   = c.src_sel;
    w[acr_pkg::CTL_POL_BIT]        = c.level_sense_polarity;
    w[acr_pkg::CTL_SENSE_LSB +: 2] = c.interrupt_sense_select;
    w[acr_pkg::CTL_INV_BIT]        = c.output_invert;
    return w;
  endfunction

  function automatic logic [31:0] stat_word(input logic v);
    logic [31:0] w;
    w                        = '0;
    w[acr_pkg::STAT_OUT_BIT] = v;
    return w;
  endfunction

  // Register state
  logic [1:0]             en_reg, en_next;
  logic [1:0]             raw_reg, raw_next;
  acr_pkg::acr_ladder_t   ref_reg, ref_next;
  acr_pkg::acr_cmp_ctrl_t ctl0_reg, ctl0_next;
  acr_pkg::acr_cmp_ctrl_t ctl1_reg, ctl1_next;
  logic                   irq_reg, irq_next;
  logic [1:0]             clr;
  logic                   cond0, cond1;
  logic                   ev0, ev1;
  logic [1:0]             masked_w;

  // Bus state
  logic                   aw_held_reg, aw_held_next;
  logic [6:0]             awaddr_reg, awaddr_next;
  logic                   w_held_reg, w_held_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic                   awready_reg, awready_next;
  logic                   wready_reg, wready_next;
  logic                   bvalid_reg, bvalid_next;
  logic [1:0]             bresp_reg, bresp_next;
  logic                   arready_reg, arready_next;
  logic                   rvalid_reg, rvalid_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [1:0]             rresp_reg, rresp_next;
  logic                   aw_hs, w_hs, ar_hs, do_write, wr_mapped;
  logic [6:0]             waddr;
  logic [31:0]            wd;
  logic [3:0]             ws;

  acr_sense u_sense0 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cmp_in    (cmp0_in),
    .ctrl      (ctl0_reg),
    .cond_out  (cond0),
    .event_out (ev0)
  );

  acr_sense u_sense1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cmp_in    (cmp1_in),
    .ctrl      (ctl1_reg),
    .cond_out  (cond1),
    .event_out (ev1)
  );

  assign masked_w = raw_reg & en_reg; // [RL4]

  // Write channel: address and data taken in either order
  always_comb begin
    aw_hs        = awvalid && awready_reg;
    w_hs         = wvalid && wready_reg;
    waddr        = aw_held_reg ? awaddr_reg : awaddr;
    wd           = w_held_reg ? wdata_reg : wdata;
    ws           = w_held_reg ? wstrb_reg : wstrb;
    do_write     = (aw_held_reg || aw_hs) && (w_held_reg || w_hs) && !bvalid_reg;
    aw_held_next = (aw_held_reg || aw_hs) && !do_write;
    w_held_next  = (w_held_reg || w_hs) && !do_write;
    awaddr_next  = aw_hs ? awaddr : awaddr_reg;
    wdata_next   = w_hs ? wdata : wdata_reg;
    wstrb_next   = w_hs ? wstrb : wstrb_reg;
    case (waddr) // [RL10]
      acr_pkg::OFS_MIS, acr_pkg::OFS_RIS, acr_pkg::OFS_INTEN,
      acr_pkg::OFS_REFCTL, acr_pkg::OFS_STAT0, acr_pkg::OFS_CTL0,
      acr_pkg::OFS_STAT1, acr_pkg::OFS_CTL1: wr_mapped = 1'b1;
      default:                               wr_mapped = 1'b0;
    endcase
    bvalid_next  = do_write || (bvalid_reg && !bready);
    if (do_write) begin
      bresp_next = wr_mapped ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
    end else begin
      bresp_next = bresp_reg;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // Register file update; reserved bits never stored
  always_comb begin
    en_next   = en_reg;
    ref_next  = ref_reg;
    ctl0_next = ctl0_reg;
    ctl1_next = ctl1_reg;
    clr       = 2'b00;
    if (do_write) begin
      case (waddr)
        acr_pkg::OFS_INTEN:  en_next = ws[0] ? wd[1:0] : en_reg; // [RL3]
        acr_pkg::OFS_RIS:    clr = ws[0] ? wd[1:0] : 2'b00;
        acr_pkg::OFS_REFCTL: begin // [RL5] [RL7] [RL8] [RL11]
          ref_next = to_ladder(apply_strb(ladder_word(ref_reg), wd, ws));
        end
        acr_pkg::OFS_CTL0:   begin // [RL11]
          ctl0_next = to_ctrl(apply_strb(ctrl_word(ctl0_reg), wd, ws));
        end
        acr_pkg::OFS_CTL1:   begin // [RL11]
          ctl1_next = to_ctrl(apply_strb(ctrl_word(ctl1_reg), wd, ws));
        end
        default:             clr = 2'b00;
      endcase
    end
    raw_next = (raw_reg & ~clr) | {ev1, ev0}; // [RL2]
    irq_next = |(raw_next & en_next); // [RL4] [RL3]
  end

  // Read channel
  always_comb begin
    ar_hs        = arvalid && arready_reg;
    rvalid_next  = ar_hs || (rvalid_reg && !rready);
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (ar_hs) begin
      rresp_next = acr_pkg::RESP_OKAY;
      case (araddr) // [RL10] [RL11]
        acr_pkg::OFS_MIS:    rdata_next = {30'h0, masked_w}; // [RL1]
        acr_pkg::OFS_RIS:    rdata_next = {30'h0, raw_reg}; // [RL2]
        acr_pkg::OFS_INTEN:  rdata_next = {30'h0, en_reg};
        acr_pkg::OFS_REFCTL: rdata_next = ladder_word(ref_reg);
        acr_pkg::OFS_STAT0:  rdata_next = stat_word(cond0); // [RL9]
        acr_pkg::OFS_CTL0:   rdata_next = ctrl_word(ctl0_reg);
        acr_pkg::OFS_STAT1:  rdata_next = stat_word(cond1); // [RL9]
        acr_pkg::OFS_CTL1:   rdata_next = ctrl_word(ctl1_reg);
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = acr_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg      <= acr_pkg::REG_RST[1:0];
      raw_reg     <= acr_pkg::REG_RST[1:0];
      ref_reg     <= to_ladder(acr_pkg::REG_RST); // [RL5]
      ctl0_reg    <= to_ctrl(acr_pkg::REG_RST);
      ctl1_reg    <= to_ctrl(acr_pkg::REG_RST);
      irq_reg     <= 1'b0;
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 7'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= acr_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= acr_pkg::RESP_OKAY;
    end else begin
      en_reg      <= en_next;
      raw_reg     <= raw_next;
      ref_reg     <= ref_next;
      ctl0_reg    <= ctl0_next;
      ctl1_reg    <= ctl1_next;
      irq_reg     <= irq_next;
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign awready      = awready_reg;
  assign wready       = wready_reg;
  assign bvalid       = bvalid_reg;
  assign bresp        = bresp_reg;
  assign arready      = arready_reg;
  assign rvalid       = rvalid_reg;
  assign rdata        = rdata_reg;
  assign rresp        = rresp_reg;
  assign ladder       = ref_reg; // [RL6] [RL7] [RL8]
  assign cmp0_src_sel = ctl0_reg.src_sel;
  assign cmp1_src_sel = ctl1_reg.src_sel;
  assign irq          = irq_reg;

  // Checks
  logic [31:0] wd_ref;
  logic [31:0] ref_word;
  assign wd_ref   = wd;
  assign ref_word = ladder_word(ref_reg);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_req(logic [6:0] a);
    arvalid && arready_reg && araddr == a;
  endsequence

  sequence wr_req(logic [6:0] a, logic lane);
    do_write && waddr == a && lane;
  endsequence

  a_irq_masked_or: assert property (irq == |masked_w) // [RL4]
    else $error("irq differs from OR of masked bits");

  a_masked_read: assert property ( // [RL1]
    rd_req(acr_pkg::OFS_MIS) |=> rvalid && rdata == {30'h0, $past(masked_w)})
    else $error("masked status read wrong");

  a_raw_set: assert property ( // [RL2]
    ev1 |=> raw_reg[1] ##0 (irq == (en_reg[1] || raw_reg[0] && en_reg[0])))
    else $error("event did not set raw status");

  a_enable_write: assert property ( // [RL3]
    wr_req(acr_pkg::OFS_INTEN, ws[0]) |=> en_reg == $past(wd_ref[1:0]))
    else $error("enable write not stored");

  a_ladder_reset: assert property ( // [RL5]
    $rose(aresetn) |-> !ladder.power && !ladder.ladder_range_select && ladder.tap == 4'h0)
    else $error("ladder not cleared by reset");

  a_ladder_hi_write: assert property ( // [RL6] [RL7]
    wr_req(acr_pkg::OFS_REFCTL, ws[1]) |=>
      (ref_word & acr_pkg::REF_HI_MASK) == ($past(wd_ref) & acr_pkg::REF_HI_MASK))
    else $error("power or range bit not applied");

  a_ladder_tap_write: assert property ( // [RL8] [RL11]
    wr_req(acr_pkg::OFS_REFCTL, ws[0]) |=> ladder.tap == $past(wd_ref[3:0])
      ##0 ref_word[7:4] == 4'h0)
    else $error("tap field not applied");

  a_stat0_read: assert property ( // [RL9] [RL10]
    rd_req(acr_pkg::OFS_STAT0) |=> rvalid && rdata == stat_word($past(cond0)))
    else $error("comparator 0 status read wrong");

  a_stat1_read: assert property ( // [RL9] [RL10]
    rd_req(acr_pkg::OFS_STAT1) |=> rvalid && rdata == stat_word($past(cond1)))
    else $error("comparator 1 status read wrong");

  a_write_resp: assert property (do_write |=> bvalid && !awready && !wready)
    else $error("write not answered");
endmodule

// file: dv/test_acr_regs.sv
module test_acr_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 aclk    = 1'b0;
  logic                 aresetn = 1'b0;
  logic [6:0]           awaddr  = 7'h00;
  logic                 awvalid = 1'b0;
  logic                 awready;
  logic [31:0]          wdata   = 32'h0;
  logic [3:0]           wstrb   = 4'h0;
  logic                 wvalid  = 1'b0;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready  = 1'b0;
  logic [6:0]           araddr  = 7'h00;
  logic                 arvalid = 1'b0;
  logic                 arready;
  logic [31:0]          rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready  = 1'b0;
  logic                 cmp0_in = 1'b1;
  logic                 cmp1_in = 1'b1;
  acr_pkg::acr_ladder_t ladder;
  logic [1:0]           cmp0_src_sel;
  logic [1:0]           cmp1_src_sel;
  logic                 irq;
  int                   err_total   = 0;
  int                   check_count = 0;
  logic [15:0]          seed = 16'h0037;
  logic [31:0]          d;
  logic [31:0]          ctl;
  logic [1:0]           r;
  logic [1:0]           m;
  logic [1:0]           en;
  logic [1:0]           e1;
  logic                 inv;
  logic [6:0]           ca;
  logic [6:0]           sa;
  logic [6:0]           offs [8];
  logic [31:0]          rst_exp [8];

  always #50 aclk = ~aclk;

  acr_regs dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cmp0_in(cmp0_in), .cmp1_in(cmp1_in), .ladder(ladder),
    .cmp0_src_sel(cmp0_src_sel), .cmp1_src_sel(cmp1_src_sel), .irq(irq)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected raw event for a conditioned edge in the given sense mode
  function automatic logic exp_raw(input logic [1:0] mode, input logic rising);
    return (mode == 2'b00) | (mode == 2'b11)
           | (mode == 2'b10 && rising) | (mode == 2'b01 && !rising);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [6:0] a, input logic [31:0] v, input logic [3:0] s,
                        output logic [1:0] resp);
    int n;
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (aw_ok && w_ok && bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    if (n == 40)
      check("write_handshake", 32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [6:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    bit ar_ok;
    ar_ok = 0;
    v = 32'h0;
    resp = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ar_ok && rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end
    end
    if (n == 40)
      check("read_handshake", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    logic [1:0] resp;
    axi_wr(a, v, 4'hf, resp);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    logic [1:0]  resp;
    axi_rd(a, v, resp);
    check(name, v, exp);
    check("rresp", {30'h0, resp}, {30'h0, acr_pkg::RESP_OKAY});
  endtask

  task automatic set_in(input int k, input logic v);
    @(posedge aclk);
    if (k == 1)
      cmp1_in <= v;
    else
      cmp0_in <= v;
  endtask

  initial begin
    #(100 * 20000);
    err_total++;
    $display("mismatch watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    offs = '{acr_pkg::OFS_MIS, acr_pkg::OFS_RIS, acr_pkg::OFS_INTEN, acr_pkg::OFS_REFCTL,
             acr_pkg::OFS_STAT0, acr_pkg::OFS_CTL0, acr_pkg::OFS_STAT1, acr_pkg::OFS_CTL1};
    // Status shows the live comparator level, both inputs held high
    rst_exp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h2, 32'h0};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk(offs[i], rst_exp[i], "reset_value");
    check("ladder_reset", {26'h0, ladder}, 32'h0);
    axi_rd(7'h0c, d, r);
    check("unmapped_rresp", {30'h0, r}, {30'h0, acr_pkg::RESP_SLVERR});
    axi_wr(7'h30, 32'hffff_ffff, 4'hf, r);
    check("unmapped_bresp", {30'h0, r}, {30'h0, acr_pkg::RESP_SLVERR});
    axi_wr(acr_pkg::OFS_MIS, 32'hffff_ffff, 4'hf, r);
    check("ro_bresp", {30'h0, r}, {30'h0, acr_pkg::RESP_OKAY});
    rd_chk(acr_pkg::OFS_MIS, 32'h0, "ro_masked");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      d = (i == 0) ? 32'hffff_ffff : {seed, lfsr_next(seed)};
      wr(acr_pkg::OFS_REFCTL, d);
      rd_chk(acr_pkg::OFS_REFCTL, d & 32'h0000_030f, "ladder_reg");
      check("ladder_port", {26'h0, ladder}, {26'h0, d[9], d[8], d[3:0]});
    end
    wr(acr_pkg::OFS_REFCTL, 32'h0000_0300);
    axi_wr(acr_pkg::OFS_REFCTL, 32'hffff_ff0a, 4'h1, r);
    rd_chk(acr_pkg::OFS_REFCTL, 32'h0000_030a, "ladder_lane");
    // Park both units in rising-edge mode, then drop inputs quietly
    wr(acr_pkg::OFS_CTL0, 32'h0000_0008);
    wr(acr_pkg::OFS_CTL1, 32'h0000_0008);
    set_in(0, 1'b0);
    set_in(1, 1'b0);
    repeat (4) @(posedge aclk);
    wr(acr_pkg::OFS_RIS, 32'h3);
    rd_chk(acr_pkg::OFS_RIS, 32'h0, "raw_cleared");
    for (int k = 0; k < 2; k++) begin
      ca = (k == 1) ? acr_pkg::OFS_CTL1 : acr_pkg::OFS_CTL0;
      sa = (k == 1) ? acr_pkg::OFS_STAT1 : acr_pkg::OFS_STAT0;
      for (int j = 0; j < 8; j++) begin
        m = j[1:0];
        inv = j[2];
        seed = lfsr_next(seed);
        en = seed[3:2];
        ctl = {21'h0, seed[1:0], 4'h0, ~inv, m, inv, 1'b0};
        wr(ca, ctl);
        rd_chk(ca, ctl, "ctl_reg");
        check("src_port", {30'h0, (k == 1) ? cmp1_src_sel : cmp0_src_sel}, {30'h0, seed[1:0]});
        wr(acr_pkg::OFS_INTEN, {30'h0, en});
        rd_chk(acr_pkg::OFS_INTEN, {30'h0, en}, "enable_reg");
        repeat (4) @(posedge aclk);
        wr(acr_pkg::OFS_RIS, 32'h3);
        set_in(k, 1'b1);
        repeat (4) @(posedge aclk);
        e1 = 2'(exp_raw(m, ~inv)) << k;
        rd_chk(acr_pkg::OFS_RIS, {30'h0, e1}, "raw_first");
        rd_chk(sa, {30'h0, ~inv, 1'b0}, "out_status");
        rd_chk(acr_pkg::OFS_MIS, {30'h0, e1 & en}, "masked");
        check("irq", {31'h0, irq}, {31'h0, |(e1 & en)});
        wr(acr_pkg::OFS_RIS, 32'h3);
        set_in(k, 1'b0);
        repeat (4) @(posedge aclk);
        e1 = 2'(exp_raw(m, inv)) << k;
        rd_chk(acr_pkg::OFS_RIS, {30'h0, e1}, "raw_second");
      end
      wr(ca, 32'h0000_0008);
    end
    summarize();
  end
endmodule
